// *** design/tpef_pkg.sv ***
// package of constants and types for the timer event flag logic
package tpef_pkg;

    // number of timer channels served
    localparam int NCH = 4;
    // flag vector: bit 0 counter wrap, bit 1+n channel n
    localparam int NFL = NCH + 1;
    localparam int FL_WRAP = 0;
    localparam int FL_CH0 = 1;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODULO = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h0c;
    localparam logic [7:0] OFS_EVT_MASK = 8'h10;
    localparam logic [7:0] OFS_CH_CTRL = 8'h20;
    localparam logic [7:0] OFS_CH_VALUE = 8'h40;
    localparam logic [7:0] OFS_CH_STEP = 8'h04;

    // control register fields
    localparam int CTRL_CENTER_BIT = 0;
    localparam int CTRL_WRAP_IE_BIT = 1;

    // channel control register fields
    localparam int CHC_MODE_LSB = 0;
    localparam int CHC_EDGE_LOW_BIT = 2;
    localparam int CHC_EDGE_HIGH_BIT = 3;
    localparam int CHC_IRQ_EN_BIT = 4;

    // channel modes while center alignment is off
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    localparam logic [1:0] MODE_EDGE_PWM = 2'h2;

    // values after reset, free-running top count and zero count
    localparam logic [15:0] MODULO_RST = 16'h0000;
    localparam logic [15:0] CH_VALUE_RST = 16'h0000;
    localparam logic [15:0] FREE_RUN_TOP = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // axi4-lite responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // per-channel configuration
    typedef struct packed {
        logic [1:0] mode;
        logic edge_select_high;
        logic edge_select_low;
        logic channel_irq_enable;
        logic [15:0] value;
    } tpef_ch_cfg_t;

    localparam tpef_ch_cfg_t CH_CFG_RST = '{
        mode: MODE_CAPTURE, edge_select_high: 1'b0, edge_select_low: 1'b0,
        channel_irq_enable: 1'b0, value: CH_VALUE_RST};

    // counter view from the surrounding timer
    typedef struct packed {
        logic step;
        logic down;
        logic [15:0] value;
    } tpef_cnt_t;

    // register decode result
    typedef enum logic [2:0] {
        SEL_CTRL, SEL_MODULO, SEL_FLAGS, SEL_EVT_STATUS, SEL_EVT_MASK,
        SEL_CH_CTRL, SEL_CH_VALUE, SEL_NONE
    } tpef_sel_kind_t;

    typedef struct packed {
        tpef_sel_kind_t kind;
        logic [1:0] idx;
    } tpef_sel_t;

    // state of one channel event detector
    typedef struct packed {
        logic pin_prev;
    } tpef_ch_state_t;

    localparam tpef_ch_state_t CH_STATE_RST = '{pin_prev: 1'b0};

endpackage

// *** design/tpef_chan_event.sv ***
// event detector for one timer channel
`timescale 1ns/100ps
`default_nettype none

module tpef_chan_event (
    input wire logic i_clk_sys,                    // system clock
    input wire logic i_sys_rst,                    // sync reset, high
    input wire tpef_pkg::tpef_ch_cfg_t i_cfg,      // channel setup
    input wire logic i_center,                     // center alignment on
    input wire tpef_pkg::tpef_cnt_t i_cnt,         // counter view
    input wire logic i_pin,                        // channel input pin
    output logic o_event                           // one-cycle event
);

    tpef_pkg::tpef_ch_state_t st_reg;
    tpef_pkg::tpef_ch_state_t st_next;
    logic rise;
    logic fall;
    logic edge_hit;
    logic match;

    ////////////////////////////////////////////////////////////////////////
    // edge and match detection
    always_comb begin
        st_next = st_reg;
        st_next.pin_prev = i_pin;
        rise = i_pin & ~st_reg.pin_prev;
        fall = ~i_pin & st_reg.pin_prev;
        // high/low select: none, rising, falling or both
        edge_hit = (i_cfg.edge_select_low & rise)
                 | (i_cfg.edge_select_high & fall);
        // counter stepped onto the channel value
        match = i_cnt.step && (i_cnt.value == i_cfg.value);
        if (i_center) begin
            // every channel is center pwm: match while up and while down
            o_event = match;
        end else begin
            case (i_cfg.mode)
                tpef_pkg::MODE_CAPTURE: begin
                    o_event = edge_hit;
                end
                tpef_pkg::MODE_COMPARE: begin
                    o_event = match;
                end
                default: begin
                    // edge pwm: match ends the active duty
                    o_event = match;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st_reg <= tpef_pkg::CH_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

`default_nettype wire

// *** design/tpef_event_flags.sv ***
// timer wrap and channel event flags with axi4-lite registers
// Operation
// - free-running counter: set wrap flag when count goes 0xffff to 0x0000
// - center off, modulo nonzero: set wrap flag when count steps from modulo to 0x0000
// - center on: set wrap flag when count turns down at modulo
// - capture channel: two edge bits pick none, rising, falling or both
// - capture channel: set channel flag on each chosen input edge
// - compare channel: set channel flag when counter steps onto its 16-bit value
// - edge pwm channel: set channel flag on match ending the duty
// - center pwm channel: set channel flag on up and down matches
// - clear flag by read while set then write zero; new event keeps it
// - per-flag level interrupt while flag and its enable are set
`timescale 1ns/100ps
`default_nettype none

module tpef_event_flags (
    input wire logic i_clk_sys,                    // system clock
    input wire logic i_sys_rst,                    // sync reset, high
    // axi4-lite slave
    input wire logic i_awvalid,                    // write address valid
    output logic o_awready,                        // write address ready
    input wire logic [7:0] i_awaddr,               // write byte address
    input wire logic i_wvalid,                     // write data valid
    output logic o_wready,                         // write data ready
    input wire logic [31:0] i_wdata,               // write data
    input wire logic [3:0] i_wstrb,                // write byte enables
    output logic o_bvalid,                         // write response valid
    input wire logic i_bready,                     // write response ready
    output logic [1:0] o_bresp,                    // write response
    input wire logic i_arvalid,                    // read address valid
    output logic o_arready,                        // read address ready
    input wire logic [7:0] i_araddr,               // read byte address
    output logic o_rvalid,                         // read data valid
    input wire logic i_rready,                     // read data ready
    output logic [31:0] o_rdata,                   // read data
    output logic [1:0] o_rresp,                    // read response
    // timer side
    input wire tpef_pkg::tpef_cnt_t i_cnt,         // counter view
    input wire logic [tpef_pkg::NCH-1:0] i_ch_pin, // channel input pins
    output logic o_center_align_select,            // up/down counting
    output logic [15:0] o_modulo,                  // modulo for counter
    output logic o_wrap_irq,                       // counter wrap request
    output logic [tpef_pkg::NCH-1:0] o_ch_irq,     // channel requests
    output logic o_irq                             // summary interrupt
);

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic center_align_select;
        logic wrap_irq_enable;
        logic [15:0] modulo;
        tpef_pkg::tpef_ch_cfg_t [tpef_pkg::NCH-1:0] ch;
        logic [tpef_pkg::NFL-1:0] flag;
        logic [tpef_pkg::NFL-1:0] arm;
        logic [tpef_pkg::NFL-1:0] evt;
        logic [tpef_pkg::NFL-1:0] mask;
        logic [15:0] cnt_prev;
        logic down_prev;
        logic wrap_irq;
        logic [tpef_pkg::NCH-1:0] ch_irq;
        logic irq;
    } tpef_state_t;

    tpef_state_t st_reg;
    tpef_state_t st_next;
    wire logic [tpef_pkg::NFL-1:0] ev;
    logic wrap_ev;
    logic [tpef_pkg::NFL-1:0] wr_clr;
    logic [tpef_pkg::NFL-1:0] rd_arm;
    logic [tpef_pkg::NFL-1:0] rd_evt_clr;
    logic [15:0] terminal;
    logic [31:0] merged;
    logic [31:0] wr_old;
    logic [31:0] rd_word;
    logic do_wr;
    tpef_pkg::tpef_sel_t wsel;
    tpef_pkg::tpef_sel_t rsel;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // map a byte address onto a register kind and channel index
    function automatic tpef_pkg::tpef_sel_t decode(input logic [7:0] a);
        tpef_pkg::tpef_sel_t s;
        s.idx = a[3:2];
        s.kind = tpef_pkg::SEL_NONE;
        if (a[1:0] == 2'h0) begin
            if (a == tpef_pkg::OFS_CTRL) begin
                s.kind = tpef_pkg::SEL_CTRL;
            end else if (a == tpef_pkg::OFS_MODULO) begin
                s.kind = tpef_pkg::SEL_MODULO;
            end else if (a == tpef_pkg::OFS_FLAGS) begin
                s.kind = tpef_pkg::SEL_FLAGS;
            end else if (a == tpef_pkg::OFS_EVT_STATUS) begin
                s.kind = tpef_pkg::SEL_EVT_STATUS;
            end else if (a == tpef_pkg::OFS_EVT_MASK) begin
                s.kind = tpef_pkg::SEL_EVT_MASK;
            end else if (a[7:4] == tpef_pkg::OFS_CH_CTRL[7:4]) begin
                s.kind = tpef_pkg::SEL_CH_CTRL;
            end else if (a[7:4] == tpef_pkg::OFS_CH_VALUE[7:4]) begin
                s.kind = tpef_pkg::SEL_CH_VALUE;
            end
        end
        return s;
    endfunction

    // pack a channel control word
    function automatic logic [31:0] ch_ctrl_word(
        input tpef_pkg::tpef_ch_cfg_t c
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[tpef_pkg::CHC_MODE_LSB +: 2] = c.mode;
        w[tpef_pkg::CHC_EDGE_LOW_BIT] = c.edge_select_low;
        w[tpef_pkg::CHC_EDGE_HIGH_BIT] = c.edge_select_high;
        w[tpef_pkg::CHC_IRQ_EN_BIT] = c.channel_irq_enable;
        return w;
    endfunction

    // read value of a register
    function automatic logic [31:0] read_word(
        input tpef_pkg::tpef_sel_t s,
        input tpef_state_t t
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (s.kind)
            tpef_pkg::SEL_CTRL: begin
                w[tpef_pkg::CTRL_CENTER_BIT] = t.center_align_select;
                w[tpef_pkg::CTRL_WRAP_IE_BIT] = t.wrap_irq_enable;
            end
            tpef_pkg::SEL_MODULO: w[15:0] = t.modulo;
            tpef_pkg::SEL_FLAGS: w[tpef_pkg::NFL-1:0] = t.flag;
            tpef_pkg::SEL_EVT_STATUS: w[tpef_pkg::NFL-1:0] = t.evt;
            tpef_pkg::SEL_EVT_MASK: w[tpef_pkg::NFL-1:0] = t.mask;
            tpef_pkg::SEL_CH_CTRL: w = ch_ctrl_word(t.ch[s.idx]);
            tpef_pkg::SEL_CH_VALUE: w[15:0] = t.ch[s.idx].value;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // channel event detectors
    genvar gi;
    generate
        for (gi = 0; gi < tpef_pkg::NCH; gi = gi + 1) begin : g_ch
            tpef_chan_event u_ev (
                .i_clk_sys(i_clk_sys),
                .i_sys_rst(i_sys_rst),
                .i_cfg(st_reg.ch[gi]),
                .i_center(st_reg.center_align_select),
                .i_cnt(i_cnt),
                .i_pin(i_ch_pin[gi]),
                .o_event(ev[tpef_pkg::FL_CH0 + gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // counter wrap event
    always_comb begin
        // with center alignment off, a modulo of zero means the full 16-bit range
        terminal = (st_reg.modulo == tpef_pkg::MODULO_RST) ?
                   tpef_pkg::FREE_RUN_TOP : st_reg.modulo;
        if (st_reg.center_align_select) begin
            // turn from up to down at the modulo value ends a period
            wrap_ev = i_cnt.step && i_cnt.down
                && !st_reg.down_prev
                && (st_reg.cnt_prev == st_reg.modulo);
        end else begin
            wrap_ev = i_cnt.step
                && (st_reg.cnt_prev == terminal)
                && (i_cnt.value == tpef_pkg::COUNT_ZERO);
        end
    end

    assign ev[tpef_pkg::FL_WRAP] = wrap_ev;

    // handshake outputs
    assign o_awready = !st_reg.aw_held;
    assign o_wready = !st_reg.w_held;
    assign o_arready = !st_reg.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // next state: bus slave, registers, flags, interrupts
    always_comb begin
        st_next = st_reg;
        wr_clr = '0;
        rd_arm = '0;
        rd_evt_clr = '0;
        wsel = decode(st_reg.aw_addr);
        rsel = decode(i_araddr);
        wr_old = read_word(wsel, st_reg);
        // write word with byte enables applied over the current value
        for (int b = 0; b < 4; b++) begin
            merged[8*b +: 8] = st_reg.w_strb[b] ?
                st_reg.w_data[8*b +: 8] : wr_old[8*b +: 8];
        end
        rd_word = read_word(rsel, st_reg);
        do_wr = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
        // address and data may come in either order
        if (i_awvalid && !st_reg.aw_held) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = i_awaddr;
        end
        if (i_wvalid && !st_reg.w_held) begin
            st_next.w_held = 1'b1;
            st_next.w_data = i_wdata;
            st_next.w_strb = i_wstrb;
        end
        if (st_reg.bvalid && i_bready) begin
            st_next.bvalid = 1'b0;
        end
        // perform the write once both halves are held
        if (do_wr) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = tpef_pkg::RESP_OKAY;
            case (wsel.kind)
                tpef_pkg::SEL_CTRL: begin
                    st_next.center_align_select =
                        merged[tpef_pkg::CTRL_CENTER_BIT];
                    st_next.wrap_irq_enable =
                        merged[tpef_pkg::CTRL_WRAP_IE_BIT];
                end
                tpef_pkg::SEL_MODULO: st_next.modulo = merged[15:0];
                tpef_pkg::SEL_FLAGS: begin
                    // a zero clears only a flag armed by an earlier read
                    wr_clr = ~merged[tpef_pkg::NFL-1:0] & st_reg.arm;
                end
                tpef_pkg::SEL_EVT_STATUS: begin
                    // read-only, write ignored
                end
                tpef_pkg::SEL_EVT_MASK: begin
                    st_next.mask = merged[tpef_pkg::NFL-1:0];
                end
                tpef_pkg::SEL_CH_CTRL: begin
                    st_next.ch[wsel.idx].mode =
                        merged[tpef_pkg::CHC_MODE_LSB +: 2];
                    st_next.ch[wsel.idx].edge_select_low =
                        merged[tpef_pkg::CHC_EDGE_LOW_BIT];
                    st_next.ch[wsel.idx].edge_select_high =
                        merged[tpef_pkg::CHC_EDGE_HIGH_BIT];
                    st_next.ch[wsel.idx].channel_irq_enable =
                        merged[tpef_pkg::CHC_IRQ_EN_BIT];
                end
                tpef_pkg::SEL_CH_VALUE: begin
                    st_next.ch[wsel.idx].value = merged[15:0];
                end
                default: st_next.bresp = tpef_pkg::RESP_SLVERR;
            endcase
        end
        // read: answer one cycle after the address is taken
        if (st_reg.rvalid && i_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (i_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word;
            st_next.rresp = (rsel.kind == tpef_pkg::SEL_NONE) ?
                tpef_pkg::RESP_SLVERR : tpef_pkg::RESP_OKAY;
            if (rsel.kind == tpef_pkg::SEL_FLAGS) begin
                rd_arm = st_reg.flag;
            end
            if (rsel.kind == tpef_pkg::SEL_EVT_STATUS) begin
                rd_evt_clr = st_reg.evt;
            end
        end
        // a new event sets the flag and cancels a pending clear
        st_next.flag = (st_reg.flag & ~wr_clr) | ev;
        st_next.arm = (st_reg.arm | rd_arm) & ~wr_clr & ~ev;
        // sticky event status, set wins over the read clear
        st_next.evt = (st_reg.evt & ~rd_evt_clr) | ev;
        // counter history for wrap detection
        if (i_cnt.step) begin
            st_next.cnt_prev = i_cnt.value;
            st_next.down_prev = i_cnt.down;
        end
        // level requests follow flags and enables; summary follows event status and mask
        st_next.wrap_irq = st_next.flag[tpef_pkg::FL_WRAP]
            & st_next.wrap_irq_enable;
        for (int n = 0; n < tpef_pkg::NCH; n++) begin
            st_next.ch_irq[n] = st_next.flag[tpef_pkg::FL_CH0 + n]
                & st_next.ch[n].channel_irq_enable;
        end
        st_next.irq = |(st_next.evt & st_next.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            st_reg <= '0;
            st_reg.modulo <= tpef_pkg::MODULO_RST;
            st_reg.ch <= {tpef_pkg::NCH{tpef_pkg::CH_CFG_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs from flip-flops
    assign o_bvalid = st_reg.bvalid;
    assign o_bresp = st_reg.bresp;
    assign o_rvalid = st_reg.rvalid;
    assign o_rdata = st_reg.rdata;
    assign o_rresp = st_reg.rresp;
    assign o_center_align_select = st_reg.center_align_select;
    assign o_modulo = st_reg.modulo;
    assign o_wrap_irq = st_reg.wrap_irq;
    assign o_ch_irq = st_reg.ch_irq;
    assign o_irq = st_reg.irq;

endmodule

`default_nettype wire

// *** verification/tpef_event_flags_sva.sv ***
// assertion checker for the timer event flag block
`timescale 1ns/100ps
`default_nettype none

module tpef_event_flags_sva (
    input wire logic i_clk_sys,              // clock
    input wire logic i_sys_rst,              // reset
    input wire logic i_awvalid,              // aw valid
    input wire logic o_awready,              // aw ready
    input wire logic i_wvalid,               // w valid
    input wire logic o_wready,               // w ready
    input wire logic o_bvalid,               // b valid
    input wire logic i_bready,               // b ready
    input wire logic [1:0] o_bresp,          // b response
    input wire logic i_arvalid,              // ar valid
    input wire logic o_arready,              // ar ready
    input wire logic o_rvalid,               // r valid
    input wire logic i_rready,               // r ready
    input wire logic [31:0] o_rdata,         // r data
    input wire tpef_pkg::tpef_cnt_t i_cnt,   // counter view
    input wire logic o_center_align_select,  // up/down mode
    input wire logic [15:0] o_modulo,        // modulo
    input wire logic o_wrap_irq,             // wrap request
    input wire logic [3:0] o_ch_irq,         // channel requests
    input wire logic o_irq                   // summary request
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////
    logic [15:0] prev_val;
    logic prev_down;
    logic wev;

    // last count and direction seen on a step
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            prev_val <= 16'h0000;
            prev_down <= 1'b0;
        end else if (i_cnt.step) begin
            prev_val <= i_cnt.value;
            prev_down <= i_cnt.down;
        end
    end

    // wrap event expected from count, mode and modulo
    assign wev = i_cnt.step && (o_center_align_select ?
        (i_cnt.down && !prev_down && prev_val == o_modulo) :
        (i_cnt.value == 16'h0000 && prev_val ==
        ((o_modulo == 16'h0000) ? 16'hffff : o_modulo)));

    ////////////////////////////////////////
    // bus handshakes and register effects
    a_reset_quiet: assert property (disable iff (1'b0) i_sys_rst |=>
        !o_bvalid && !o_rvalid && !o_irq && !o_wrap_irq && o_ch_irq == 4'h0)
        else $error("outputs active after reset");
    a_read_latency: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    a_rvalid_hold: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata)) else $error("read data dropped");
    a_ar_blocked: assert property (o_rvalid |-> !o_arready)
        else $error("read address taken while answer pending");
    a_bvalid_hold: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
        o_wready && !o_bvalid |-> ##2 o_bvalid)
        else $error("write answer late");
    a_modulo_by_write: assert property ($changed(o_modulo) |->
        $rose(o_bvalid)) else $error("modulo changed without write");
    a_wrap_irq_cause: assert property ($rose(o_wrap_irq) |->
        $past(wev) || $rose(o_bvalid)) else $error("wrap request uncaused");
    a_wrap_irq_clear: assert property ($fell(o_wrap_irq) |->
        $rose(o_bvalid)) else $error("wrap request fell without write");
    a_ch_irq_clear: assert property (
        ($past(o_ch_irq) & ~o_ch_irq) != 4'h0 |-> $rose(o_bvalid))
        else $error("channel request fell");
    a_irq_clear: assert property ($fell(o_irq) |->
        $rose(o_bvalid) || $rose(o_rvalid)) else $error("summary fell");
endmodule

bind tpef_event_flags tpef_event_flags_sva u_sva (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_rdata(o_rdata), .i_cnt(i_cnt), .o_modulo(o_modulo),
    .o_center_align_select(o_center_align_select), .o_irq(o_irq),
    .o_wrap_irq(o_wrap_irq), .o_ch_irq(o_ch_irq));
`default_nettype wire

// *** verification/tb_timer_event_flag_logic.sv ***
// self-checking bench for the timer event flag block
`timescale 1ns/100ps
`default_nettype none

module tb_timer_event_flag_logic;
    localparam logic [7:0] FL = tpef_pkg::OFS_FLAGS;
    localparam logic [7:0] CC = tpef_pkg::OFS_CH_CTRL;
    localparam logic [7:0] CV = tpef_pkg::OFS_CH_VALUE;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h00000000;
    tpef_pkg::tpef_cnt_t cnt = '0;
    logic [3:0] pin = 4'h0;
    logic awr, wrd, bv, arr, rv, cen, wirq, irq;
    logic [1:0] br, rr, resp;
    logic [31:0] rdat, rdv;
    logic [15:0] mdl;
    logic [3:0] chirq;
    int mismatches = 0;
    int n_checks = 0;

    tpef_event_flags u_dut (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
        .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv),
        .i_bready(bry), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
        .i_araddr(ara), .o_rvalid(rv), .i_rready(rry), .o_rdata(rdat),
        .o_rresp(rr), .i_cnt(cnt), .i_ch_pin(pin),
        .o_center_align_select(cen), .o_modulo(mdl), .o_wrap_irq(wirq),
        .o_ch_irq(chirq), .o_irq(irq));

    ////////////////////////////////////////
    // 125 mhz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    // axi4-lite write; readies are sampled settled, at the falling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta | awr;
            tw = tw | wrd;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        do @(negedge clk); while (!bv);
        resp = br;
        @(posedge clk);
        bry <= 1'b0;
    endtask

    // axi4-lite read
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(negedge clk); while (!arr);
        @(posedge clk);
        arv <= 1'b0;
        do @(negedge clk); while (!rv);
        rdv = rdat;
        resp = rr;
        @(posedge clk);
        rry <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdv, e);
    endtask

    // one counter step pulse with new value and direction
    task automatic stp(input logic [15:0] v, input logic dn);
        @(posedge clk);
        cnt <= '{step: 1'b1, down: dn, value: v};
        @(posedge clk);
        cnt.step <= 1'b0;
    endtask

    // read arms, write zero clears, status read empties
    task automatic clr();
        rd(FL);
        wr(FL, 32'h0);
        rd(tpef_pkg::OFS_EVT_STATUS);
    endtask

    ////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        $display("unexpected at %0t: timeout", $time);
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rc(tpef_pkg::OFS_CTRL, 32'h0);
        rc(CC, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(8'h3c);
        chk({30'h0, resp}, {30'h0, tpef_pkg::RESP_SLVERR});
        wr(8'h02, 32'h1);
        chk({30'h0, resp}, {30'h0, tpef_pkg::RESP_SLVERR});
        stp(16'hfffe, 1'b0);
        stp(16'hffff, 1'b0);
        rc(FL, 32'h0);
        stp(16'h0000, 1'b0);
        rc(FL, 32'h1);
        stp(16'hffff, 1'b0);
        stp(16'h0000, 1'b0);
        wr(FL, 32'h0);
        rc(FL, 32'h1);
        wr(FL, 32'h0);
        rc(FL, 32'h0);
        wr(tpef_pkg::OFS_MODULO, 32'h10);
        stp(16'h000f, 1'b0);
        stp(16'h0010, 1'b0);
        rc(FL, 32'h0);
        stp(16'h0000, 1'b0);
        rc(FL, 32'h1);
        clr();
        for (int m = 1; m < 3; m++) begin
            wr(CC + 8'(4 * m), 32'(m) | 32'h10);
            wr(CV + 8'(4 * m), 32'h1234 + 32'(m));
            stp(16'h9234 + 16'(m), 1'b0);
            rc(FL, 32'h0);
            stp(16'h1234 + 16'(m), 1'b0);
            rc(FL, 32'h1 << (m + 1));
            chk({28'h0, chirq}, 32'h1 << m);
            clr();
            chk({28'h0, chirq}, 32'h0);
        end
        for (int e = 0; e < 4; e++) begin
            wr(CC + 8'h0c, 32'(e) << 2);
            @(posedge clk);
            pin <= 4'h8;
            rc(FL, e[0] ? 32'h10 : 32'h0);
            clr();
            @(posedge clk);
            pin <= 4'h0;
            rc(FL, e[1] ? 32'h10 : 32'h0);
            clr();
        end
        wr(tpef_pkg::OFS_CTRL, 32'h2);
        wr(tpef_pkg::OFS_EVT_MASK, 32'h1);
        stp(16'h0010, 1'b0);
        stp(16'h0000, 1'b0);
        @(posedge clk);
        chk({30'h0, wirq, irq}, 32'h3);
        rc(tpef_pkg::OFS_EVT_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        clr();
        chk({31'h0, wirq}, 32'h0);
        wr(tpef_pkg::OFS_CTRL, 32'h1);
        chk({15'h0, cen, mdl}, 32'h10010);
        wr(CV + 8'h04, 32'h8);
        clr();
        stp(16'h0008, 1'b0);
        rc(FL, 32'h4);
        clr();
        stp(16'h000f, 1'b0);
        stp(16'h0010, 1'b0);
        rc(FL, 32'h0);
        stp(16'h000f, 1'b1);
        rc(FL, 32'h1);
        clr();
        stp(16'h0008, 1'b1);
        rc(FL, 32'h4);
        report_and_stop();
    end
endmodule
`default_nettype wire
